/* File: modem_change.sv */
`timescale 1ns/1ps
module modem_change (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Current line state, active high
    input wire uart_status_pkg::modem_lines_t lines,
    // Modem status read strobe
    input wire logic clear,
    // Change indicators and new-change pulse
    output uart_status_pkg::modem_lines_t delta,
    output logic changed
);
    typedef struct packed {
        logic primed;
        uart_status_pkg::modem_lines_t prev;
        uart_status_pkg::modem_lines_t delta;
    } state_t;

    state_t q;
    state_t d;
    uart_status_pkg::modem_lines_t edge_seen;

    // No compare until prev holds a real sample, else reset fakes a change
    assign edge_seen = q.primed ? (lines ^ q.prev) : '0;
    assign delta = q.delta;
    assign changed = |edge_seen;

    always_comb begin
        d = q;
        d.primed = 1'b1;
        d.prev = lines;
        // A change in the read cycle survives the clear
        d.delta = (clear ? '0 : q.delta) | edge_seen;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: modem_model.sv */
`timescale 1ns/1ps
module modem_model (
    // Clock
    input wire logic sys_clk,
    // Wanted line state, active high: cd ri dsr cts
    input wire logic [3:0] want,
    // Modem pins, active low
    output logic carrier_detect_input_n,
    output logic ring_indicator_input_n,
    output logic data_set_ready_input_n,
    output logic clear_to_send_input_n
);
    // ==========
    // Lines change only after an edge, as the block expects them synchronous
    initial begin
        {carrier_detect_input_n, ring_indicator_input_n,
            data_set_ready_input_n, clear_to_send_input_n} = 4'hf;
    end
    always @(posedge sys_clk) begin
        {carrier_detect_input_n, ring_indicator_input_n,
            data_set_ready_input_n, clear_to_send_input_n} <= ~want;
    end
endmodule

/* File: rx_fifo.sv */
`timescale 1ns/1ps
module rx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control
    input wire logic flush,
    input wire logic one_deep,
    // Fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_MAX = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] count;
    } state_t;

    state_t q;
    state_t d;
    logic do_push;
    logic do_pop;

    // Holding-register mode is the same storage limited to one entry
    assign full = one_deep ? (q.count >= CNT_ONE) : (q.count == CNT_MAX);
    assign empty = (q.count == '0);
    assign head = q.mem[q.rd];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_comb begin
        d = q;
        if (do_push) begin
            d.mem[q.wr] = push_data;
            d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
        end
        if (do_pop) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
        end
        d.count = q.count + CW'(do_push) - CW'(do_pop);
        if (flush) begin
            d.wr = '0;
            d.rd = '0;
            d.count = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: uart_line_and_modem_status_tb.sv */
`timescale 1ns/1ps
module uart_line_and_modem_status_tb;
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] A_RX = uart_status_pkg::ADDR_RX_DATA;
    localparam logic [2:0] A_LS = uart_status_pkg::ADDR_LINE_STATUS;
    localparam logic [2:0] A_MS = uart_status_pkg::ADDR_MODEM_STATUS;
    localparam logic [2:0] A_CTL = uart_status_pkg::ADDR_CONTROL;
    localparam logic [2:0] A_ICL = uart_status_pkg::ADDR_IRQ_CLEAR;
    localparam logic [2:0] A_IST = uart_status_pkg::ADDR_IRQ_STATUS;
    localparam logic [2:0] A_IEN = uart_status_pkg::ADDR_IRQ_ENABLE;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic char_done = 1'b0;
    uart_status_pkg::rx_char_t char_in = '0;
    logic [3:0] modem_want = 4'h0;
    logic [7:0] rd_data, rd_q;
    logic irq, cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, out1_n, out2_n;
    int fails = 0;
    int n_tests = 0;

    always #2.5 sys_clk = ~sys_clk;

    uart_status_top #(.FIFO_DEPTH(FIFO_DEPTH)) i_uart_status_top (
        .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .char_done(char_done), .char_in(char_in),
        .clear_to_send_input_n(cts_n), .data_set_ready_input_n(dsr_n),
        .ring_indicator_input_n(ri_n), .carrier_detect_input_n(cd_n),
        .request_to_send_n(rts_n), .data_terminal_ready_n(dtr_n),
        .user_output_one_n(out1_n), .user_output_two_n(out2_n), .irq(irq));
    modem_model i_modem_model (.sys_clk(sys_clk), .want(modem_want),
        .carrier_detect_input_n(cd_n), .ring_indicator_input_n(ri_n),
        .data_set_ready_input_n(dsr_n), .clear_to_send_input_n(cts_n));

    // ==========
    // Bus tasks
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic rc(input string what, input logic [2:0] a,
        input logic [7:0] exp);
        rd(a, rd_q);
        chk(what, exp, rd_q);
    endtask
    task automatic push(input uart_status_pkg::rx_char_t c);
        @(posedge sys_clk);
        char_done <= 1'b1;
        char_in <= c;
        @(posedge sys_clk);
        char_done <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========
    // Tests
    initial begin
        #100000;
        fails++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rc("line_status", A_LS, 8'h00);
        rc("modem_status", A_MS, 8'h00);
        rc("unmapped", 3'h7, 8'h00);
        $display("test reset done");
        wr(A_IEN, 8'h01);
        push(11'h15a);
        @(posedge sys_clk);
        #1 chk("irq", 8'h01, {7'h00, irq});
        rc("line_status", A_LS, 8'h85);
        rc("line_status", A_LS, 8'h05);
        push(11'h0a5);
        rc("line_status", A_LS, 8'h07);
        rc("rx_data", A_RX, 8'h5a);
        rc("line_status", A_LS, 8'h00);
        rc("irq_status", A_IST, 8'h03);
        rc("irq_enable", A_IEN, 8'h01);
        wr(A_ICL, 8'h07);
        @(posedge sys_clk);
        #1 chk("irq", 8'h00, {7'h00, irq});
        rc("irq_status", A_IST, 8'h00);
        $display("test holding done");
        wr(A_CTL, 8'h20);
        push(11'h211);
        for (int i = 2; i < 6; i++) push(11'(8'h11 * i));
        rc("line_status", A_LS, 8'h8b);
        rc("rx_data", A_RX, 8'h11);
        rc("line_status", A_LS, 8'h01);
        for (int i = 2; i < 5; i++) begin
            rc("rx_data", A_RX, 8'(8'h11 * i));
        end
        rc("line_status", A_LS, 8'h00);
        $display("test fifo done");
        wr(A_IEN, 8'h04);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            modem_want[i] <= 1'b1;
            repeat (3) @(posedge sys_clk);
            #1 chk("irq", 8'h01, {7'h00, irq});
            rc("modem_status", A_MS,
                8'((((1 << (i + 1)) - 1) << 4) | (1 << i)));
            rc("modem_status", A_MS,
                8'(((1 << (i + 1)) - 1) << 4));
            wr(A_ICL, 8'h04);
        end
        $display("test modem done");
        wr(A_CTL, 8'h0f);
        repeat (3) @(posedge sys_clk);
        #1 chk("pins", 8'h00, {4'h0, out2_n, out1_n, rts_n, dtr_n});
        wr(A_CTL, 8'h13);
        repeat (3) @(posedge sys_clk);
        #1 chk("pins", 8'h0f, {4'h0, out2_n, out1_n, rts_n, dtr_n});
        rd(A_MS, rd_q);
        chk("modem_status", 8'h30, rd_q & 8'hf0);
        rc("control", A_CTL, 8'h13);
        $display("test loopback done");
        final_report();
    end
endmodule

bind uart_status_top uart_status_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .char_done(char_done),
    .char_in(char_in), .clear_to_send_input_n(clear_to_send_input_n),
    .data_set_ready_input_n(data_set_ready_input_n),
    .ring_indicator_input_n(ring_indicator_input_n),
    .carrier_detect_input_n(carrier_detect_input_n),
    .request_to_send_n(request_to_send_n),
    .data_terminal_ready_n(data_terminal_ready_n),
    .user_output_one_n(user_output_one_n),
    .user_output_two_n(user_output_two_n), .irq(irq));

/* File: uart_status_chk.sv */
`timescale 1ns/1ps
module uart_status_chk #(
    parameter int FIFO_DEPTH = 64
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    // Receiver
    input wire logic char_done,
    input wire uart_status_pkg::rx_char_t char_in,
    // Modem pins
    input wire logic clear_to_send_input_n,
    input wire logic data_set_ready_input_n,
    input wire logic ring_indicator_input_n,
    input wire logic carrier_detect_input_n,
    input wire logic request_to_send_n,
    input wire logic data_terminal_ready_n,
    input wire logic user_output_one_n,
    input wire logic user_output_two_n,
    input wire logic irq
);
    // ==========
    // Shadow state
    logic [7:0] ctl_q, en_q, cnt_q, cap;
    logic ovr_q, err_q, rd_ls, rd_ms, wr_ctl, flush, push, pop;
    logic [3:0] pins, exp_hi;
    assign pins = {carrier_detect_input_n, ring_indicator_input_n,
        data_set_ready_input_n, clear_to_send_input_n};
    assign exp_hi = ctl_q[4] ? {ctl_q[3:2], ctl_q[0], ctl_q[1]} : ~pins;
    assign rd_ls = rd_en && addr == uart_status_pkg::ADDR_LINE_STATUS;
    assign rd_ms = rd_en && addr == uart_status_pkg::ADDR_MODEM_STATUS;
    assign wr_ctl = wr_en && addr == uart_status_pkg::ADDR_CONTROL;
    assign cap = ctl_q[5] ? 8'(FIFO_DEPTH) : 8'h01;
    // Mode toggle empties the store and drops that cycle's char
    assign flush = wr_ctl && wr_data[5] != ctl_q[5];
    assign push = char_done && !flush && cnt_q != cap;
    assign pop = rd_en && addr == uart_status_pkg::ADDR_RX_DATA && cnt_q != 0;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctl_q <= 8'h00;
            en_q <= 8'h00;
            cnt_q <= 8'h00;
            ovr_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_q <= wr_data & 8'h3f;
            end
            if (wr_en && addr == uart_status_pkg::ADDR_IRQ_ENABLE) begin
                en_q <= wr_data;
            end
            cnt_q <= flush ? 8'h00 : cnt_q + 8'(push) - 8'(pop);
            ovr_q <= (char_done && !flush && cnt_q == cap) || (ovr_q && !rd_ls);
            err_q <= (push && char_in[10:8] != 3'h0) || (err_q && !rd_ls);
        end
    end
    // ==========
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_calm;
        $stable(pins) && $stable(ctl_q);
    endsequence
    sequence s_ls;
        rd_ls && !char_done && !$past(char_done);
    endsequence
    AST_RESET_OUT:
    assert property (@(posedge sys_clk) disable iff (1'b0) !reset_n |=>
        rd_data == 8'h00 && !irq && request_to_send_n && user_output_two_n)
        else $error("outputs not idle after reset");
    AST_HEAD_EMPTY:
    assert property (s_ls ##0 cnt_q == 8'h00 |=> rd_data[4:2] == 3'h0)
        else $error("head flags set while empty");
    AST_DATA_READY:
    assert property (s_ls |=> rd_data[0] == ($past(cnt_q) != 8'h00))
        else $error("data ready wrong");
    AST_OVERRUN:
    assert property (s_ls |=> rd_data[1] == $past(ovr_q))
        else $error("overrun flag wrong");
    AST_FIFO_ERR:
    assert property (s_ls |=> rd_data[7] == $past(err_q))
        else $error("fifo error flag wrong");
    // Host reads the status a few cycles after a line moves
    AST_MODEM_SET:
    assert property ($changed(pins) && !ctl_q[4] && !wr_en
        ##1 !rd_ms [*2] ##1 rd_ms |=> rd_data[3:0] != 4'h0)
        else $error("change not flagged");
    AST_MODEM_CLEAR:
    assert property (s_calm ##1 (rd_ms ##0 s_calm) ##1 s_calm
        ##1 (rd_ms ##0 s_calm) |=> rd_data[3:0] == 4'h0)
        else $error("change bits survive read");
    AST_MODEM_LEVELS:
    assert property (s_calm ##1 (rd_ms ##0 s_calm) |=>
        rd_data[7:4] == $past(exp_hi)) else $error("line state wrong");
    AST_LOOP_PINS:
    assert property ($stable(ctl_q) [*3] |-> {user_output_two_n,
        user_output_one_n, request_to_send_n, data_terminal_ready_n} ==
        (ctl_q[4] ? 4'hf : ~ctl_q[3:0])) else $error("control pins wrong");
    AST_IRQ_RX:
    assert property (push && en_q[0] && !wr_en |-> ##[1:2] irq)
        else $error("no receive interrupt");
    AST_IRQ_CD:
    assert property ($changed(carrier_detect_input_n) && !ctl_q[4] && en_q[2]
        && !wr_en |-> ##[1:3] irq) else $error("no modem interrupt");
endmodule

/* File: uart_status_pkg.sv */
// Behaviour
// - Framing-error flag is set for a character without a valid stop bit, and in FIFO mode it shows the character at the head of the FIFO.
// - Parity-error flag (line status bit 2) is set for a character with wrong parity, and in FIFO mode it shows the head character.
// - Overrun flag (line status bit 1) is set when a new character completes while the receive FIFO is full.
// - On overrun the new character overwrites the shift register and is not written into the full FIFO.
// - Data-ready flag (line status bit 0) is high while the holding register or FIFO holds a character.
// - Framing, parity, overrun and data-ready flags reset to zero.
// - Modem status shows the current state of the control inputs in its upper four bits and four change indicators below.
// - A change indicator is set whenever its control input changes state.
// - Reading modem status clears all four change indicators.
// - FIFO-error flag (line status bit 7) is set while an errored character is in the FIFO data and cleared by a line status read.
//   Here it is set when an errored character is pushed, and the read clears it even while one is still held.
// - A carrier-detect change sets modem status bit 3 and raises the modem status interrupt.
// - Clear-to-send status is the complement of its input, or the request-to-send control bit in loop-back mode.
package uart_status_pkg;

    // =========================================================
    // Register map
    localparam logic [2:0] ADDR_RX_DATA = 3'h0;
    localparam logic [2:0] ADDR_LINE_STATUS = 3'h1;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h2;
    localparam logic [2:0] ADDR_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_CLEAR = 3'h5;
    localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h6;

    // =========================================================
    // Control register fields
    localparam int CTL_DTR = 0;
    localparam int CTL_RTS = 1;
    localparam int CTL_OUT1 = 2;
    localparam int CTL_OUT2 = 3;
    localparam int CTL_LOOP = 4;
    localparam int CTL_FIFO_EN = 5;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // =========================================================
    // Interrupt status fields
    localparam int IRQ_RX_READY = 0;
    localparam int IRQ_LINE_ERR = 1;
    localparam int IRQ_MODEM = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // =========================================================
    // Receive FIFO
    localparam int RX_FIFO_DEPTH = 64;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic brk;
        logic frame_err;
        logic parity_err;
        logic [7:0] data;
    } rx_char_t;

    // Bit order matches modem status 7:4 and 3:0
    typedef struct packed {
        logic carrier_detect;
        logic ring;
        logic data_set_ready;
        logic clear_to_send;
    } modem_lines_t;

endpackage

/* File: uart_status_top.sv */
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module uart_status_top #(
    parameter int FIFO_DEPTH = uart_status_pkg::RX_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Receiver character hand-off
    input wire logic char_done,
    input wire uart_status_pkg::rx_char_t char_in,
    // Modem control inputs, active low
    input wire logic clear_to_send_input_n,
    input wire logic data_set_ready_input_n,
    input wire logic ring_indicator_input_n,
    input wire logic carrier_detect_input_n,
    // Modem control outputs, active low
    output logic request_to_send_n,
    output logic data_terminal_ready_n,
    output logic user_output_one_n,
    output logic user_output_two_n,
    // Interrupt
    output logic irq
);
    typedef struct packed {
        logic [7:0] rd_data;
        logic irq;
        logic [7:0] ctrl;
        logic [2:0] ev;
        logic [2:0] ev_en;
        logic overrun;
        logic fifo_err;
        uart_status_pkg::rx_char_t shifter;
        logic [3:0] pins_n;
    } state_t;

    state_t q;
    state_t d;

    // =========================================================
    // Submodule wiring
    uart_status_pkg::rx_char_t head;
    uart_status_pkg::modem_lines_t lines;
    uart_status_pkg::modem_lines_t delta;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_flush;
    logic fifo_pop;
    logic modem_changed;
    logic rd_rx;
    logic rd_line;
    logic rd_modem;
    logic loop;
    logic push;
    logic overrun_now;
    logic char_bad;
    logic [7:0] line_status;

    assign loop = q.ctrl[uart_status_pkg::CTL_LOOP];
    assign rd_rx = rd_en && (addr == uart_status_pkg::ADDR_RX_DATA);
    assign rd_line = rd_en && (addr == uart_status_pkg::ADDR_LINE_STATUS);
    assign rd_modem = rd_en && (addr == uart_status_pkg::ADDR_MODEM_STATUS);
    assign fifo_pop = rd_rx;
    // Mode change empties the store, so no stale entry crosses modes
    assign fifo_flush = wr_en && (addr == uart_status_pkg::ADDR_CONTROL)
        && (wr_data[uart_status_pkg::CTL_FIFO_EN]
            != q.ctrl[uart_status_pkg::CTL_FIFO_EN]);
    assign push = char_done && !fifo_full && !fifo_flush;
    assign overrun_now = char_done && fifo_full && !fifo_flush;
    assign char_bad = char_in.parity_err || char_in.frame_err || char_in.brk;

    // Loop-back returns the control bits as the modem lines
    always_comb begin
        if (loop) begin
            lines.carrier_detect = q.ctrl[uart_status_pkg::CTL_OUT2];
            lines.ring = q.ctrl[uart_status_pkg::CTL_OUT1];
            lines.data_set_ready = q.ctrl[uart_status_pkg::CTL_DTR];
            lines.clear_to_send = q.ctrl[uart_status_pkg::CTL_RTS];
        end else begin
            lines.carrier_detect = ~carrier_detect_input_n;
            lines.ring = ~ring_indicator_input_n;
            lines.data_set_ready = ~data_set_ready_input_n;
            lines.clear_to_send = ~clear_to_send_input_n;
        end
    end

    rx_fifo #(
        .WIDTH($bits(uart_status_pkg::rx_char_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .flush(fifo_flush),
        .one_deep(!q.ctrl[uart_status_pkg::CTL_FIFO_EN]),
        .push(push),
        .push_data(char_in),
        .pop(fifo_pop),
        .head(head),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    modem_change u_modem_change (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .lines(lines),
        .clear(rd_modem),
        .delta(delta),
        .changed(modem_changed)
    );

    // =========================================================
    // Line status image
    // Head flags read zero when nothing is held, never a stale entry
    always_comb begin
        line_status = 8'h00;
        line_status[0] = !fifo_empty;
        line_status[1] = q.overrun;
        line_status[2] = !fifo_empty && head.parity_err;
        line_status[3] = !fifo_empty && head.frame_err;
        line_status[4] = !fifo_empty && head.brk;
        line_status[7] = q.fifo_err;
    end

    // =========================================================
    // Next state
    always_comb begin
        d = q;
        // Shifter always takes the newest character, even on overrun
        if (char_done) begin
            d.shifter = char_in;
        end

        if (rd_line) begin
            d.overrun = 1'b0;
            d.fifo_err = 1'b0;
        end
        if (overrun_now) begin
            d.overrun = 1'b1;
        end
        if (push && char_bad) begin
            d.fifo_err = 1'b1;
        end

        if (rd_en) begin
            case (addr)
                uart_status_pkg::ADDR_RX_DATA: d.rd_data = head.data;
                uart_status_pkg::ADDR_LINE_STATUS: d.rd_data = line_status;
                uart_status_pkg::ADDR_MODEM_STATUS:
                    d.rd_data = {lines, delta};
                uart_status_pkg::ADDR_CONTROL: d.rd_data = q.ctrl;
                uart_status_pkg::ADDR_IRQ_STATUS: d.rd_data = {5'h00, q.ev};
                uart_status_pkg::ADDR_IRQ_ENABLE:
                    d.rd_data = {5'h00, q.ev_en};
                default: d.rd_data = 8'h00;
            endcase
        end

        if (wr_en) begin
            case (addr)
                uart_status_pkg::ADDR_CONTROL: d.ctrl = {2'h0, wr_data[5:0]};
                uart_status_pkg::ADDR_IRQ_CLEAR: d.ev = q.ev & ~wr_data[2:0];
                uart_status_pkg::ADDR_IRQ_ENABLE: d.ev_en = wr_data[2:0];
                default: d.ev = d.ev;
            endcase
        end

        // Events set after the clear so a same-cycle event is kept
        if (push) begin
            d.ev[uart_status_pkg::IRQ_RX_READY] = 1'b1;
        end
        if (overrun_now || (push && char_bad)) begin
            d.ev[uart_status_pkg::IRQ_LINE_ERR] = 1'b1;
        end
        if (modem_changed) begin
            d.ev[uart_status_pkg::IRQ_MODEM] = 1'b1;
        end
        d.irq = |(d.ev & d.ev_en);

        // Pins idle while looped back so the far end sees nothing
        d.pins_n[0] = ~(d.ctrl[uart_status_pkg::CTL_RTS]
            & ~d.ctrl[uart_status_pkg::CTL_LOOP]);
        d.pins_n[1] = ~(d.ctrl[uart_status_pkg::CTL_DTR]
            & ~d.ctrl[uart_status_pkg::CTL_LOOP]);
        d.pins_n[2] = ~(d.ctrl[uart_status_pkg::CTL_OUT1]
            & ~d.ctrl[uart_status_pkg::CTL_LOOP]);
        d.pins_n[3] = ~(d.ctrl[uart_status_pkg::CTL_OUT2]
            & ~d.ctrl[uart_status_pkg::CTL_LOOP]);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q <= '0;
            q.ctrl <= uart_status_pkg::CONTROL_RESET;
            q.ev <= uart_status_pkg::IRQ_RESET;
            q.ev_en <= uart_status_pkg::IRQ_RESET;
            q.pins_n <= 4'hf;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign irq = q.irq;
    assign request_to_send_n = q.pins_n[0];
    assign data_terminal_ready_n = q.pins_n[1];
    assign user_output_one_n = q.pins_n[2];
    assign user_output_two_n = q.pins_n[3];
endmodule
